// file: rtl/dcsi_pkg.sv
// Constants, command codes, register map and frame states of the DAC serial command interface.
// Assumes a single 10 MHz ref_clk domain; the serial pins are asynchronous to it.
package dcsi_pkg;

  // Frame layout
  localparam int FRAME_BITS = 16;
  localparam int CMD_W = 4;
  localparam int FIELD_W = FRAME_BITS - CMD_W;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] CNT_FULL = 5'h10;
  localparam logic [CNT_W-1:0] CNT_LAST = 5'h0f;

  // Command field codes
  localparam logic [CMD_W-1:0] CMD_NOP = 4'h0;
  localparam logic [CMD_W-1:0] CMD_LOAD = 4'h1;
  localparam logic [CMD_W-1:0] CMD_READBACK = 4'h2;
  localparam logic [CMD_W-1:0] CMD_DAISY_OFF = 4'h9;
  localparam logic [CMD_W-1:0] CMD_RISING = 4'ha;
  localparam logic [CMD_W-1:0] CMD_CLR_ZERO = 4'hb;
  localparam logic [CMD_W-1:0] CMD_CLR_MID = 4'hc;

  // Register byte offsets
  localparam logic [3:0] REG_DAC = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_CTRL = 4'h8;
  localparam logic [3:0] REG_LASTCMD = 4'hc;

  // Field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int ST_DAISY_BIT = 0;
  localparam int ST_RISE_BIT = 1;
  localparam int ST_FRAME_BIT = 2;
  localparam int ST_DONE_BIT = 3;
  localparam int ST_CNT_LSB = 8;

  // Reset values
  localparam logic CTRL_EN_RESET = 1'b1;
  localparam logic DAISY_RESET = 1'b1;
  localparam logic RISING_RESET = 1'b0;
  localparam logic [FRAME_BITS-1:0] SHIFT_RESET = 16'h0000;

  typedef enum logic [1:0] {
    FR_IDLE,
    FR_SHIFT,
    FR_DONE
  } dcsi_frame_t;

endpackage

// file: rtl/dcsi_sync2.sv
// Two-flip-flop synchroniser for a group of independent asynchronous levels.
// Assumes each bit is a slow level or a clock well below half of ref_clk.
`timescale 1ns/100ps
module dcsi_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      syncOut <= '0;
    end else begin
      meta_q <= asyncIn;
      syncOut <= meta_q;
    end
  end

endmodule // dcsi_sync2

// file: rtl/dcsi_edge.sv
// Edge detector on an already synchronised level.
// Assumes the input is in the ref_clk domain; reset level is a parameter.
`timescale 1ns/100ps
module dcsi_edge #(
  parameter logic RESET_LEVEL = 1'b0
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic level,
  output logic rise,
  output logic fall
);

  logic prev_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_q <= RESET_LEVEL;
    end else begin
      prev_q <= level;
    end
  end

  assign rise = level & ~prev_q;
  assign fall = ~level & prev_q;

endmodule // dcsi_edge

// file: rtl/dcsi_serial_dac_if.sv
// Serial command interface of a current-output converter: frame decode, daisy chain,
// standalone bit counting and an Avalon-MM register view of its state.
// Assumes frameSelN, shiftClk and serialIn come from pins, slower than ref_clk / 4.
`timescale 1ns/100ps
// Operation
// - Frame is 16 bits: 4-bit command on top, left-aligned code after it.
// - Decode nop, load, readback, chain off, rising edge, clear zero, clear midscale.
// - After reset capture on falling clock edges with daisy chain on.
// - After reset the DAC register holds zero.
// - Rising-edge command moves capture to rising shift-clock edges.
// - Clear-to-zero command forces the DAC register to zero.
// - Clear-to-midscale command sets only the top data bit.
// - Readback command puts the DAC register into the shifter for output.
// - Bits are taken only while frame select is low.
// - Daisy chain mode shifts every clock while frame select stays low.
// - Beyond 16 clocks the oldest bits leave on the chain output.
// - Chain output changes on the edge opposite the capture edge.
// - After frame select rises no more bits enter the shifter.
// - Daisy chain mode executes the shifter contents on frame select rising after 16 or more clocks.
// - No-operation command leaves DAC and settings unchanged.
// - Standalone mode clears the bit counter on frame select falling.
// - Standalone frame ended early is aborted with no effect.
// - Standalone mode executes on the sixteenth capture edge.
// - Standalone mode ignores clocks until frame select falls again.
module dcsi_serial_dac_if #(
  parameter int DATA_W = 12
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic frameSelN,
  input wire logic shiftClk,
  input wire logic serialIn,
  output logic chainOut,
  output logic [DATA_W-1:0] dacCode,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);

  localparam int PAD = dcsi_pkg::FIELD_W - DATA_W;

  // Pin synchronisation and edge finding
  logic [2:0] pinSync;
  logic frameSync;
  logic clkSync;
  logic dinSync;
  logic frameRise;
  logic frameFall;
  logic clkRise;
  logic clkFall;

  // Frame select enters inverted so the synchroniser's zero reset reads as idle high
  dcsi_sync2 #(
    .WIDTH(3)
  ) u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .asyncIn({~frameSelN, shiftClk, serialIn}),
    .syncOut(pinSync)
  );

  assign frameSync = ~pinSync[2];
  assign clkSync = pinSync[1];
  assign dinSync = pinSync[0];

  // Reset level high so a frame select idling high gives no false edge
  dcsi_edge #(
    .RESET_LEVEL(1'b1)
  ) u_frame_edge (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .level(frameSync),
    .rise(frameRise),
    .fall(frameFall)
  );

  dcsi_edge #(
    .RESET_LEVEL(1'b0)
  ) u_clk_edge (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .level(clkSync),
    .rise(clkRise),
    .fall(clkFall)
  );

  // State
  dcsi_pkg::dcsi_frame_t frameState_q;
  dcsi_pkg::dcsi_frame_t frameState_d;
  logic [dcsi_pkg::FRAME_BITS-1:0] shiftReg_q;
  logic [dcsi_pkg::FRAME_BITS-1:0] shiftReg_d;
  logic [dcsi_pkg::CNT_W-1:0] bitCount_q;
  logic [dcsi_pkg::CNT_W-1:0] bitCount_d;
  logic [DATA_W-1:0] dacCode_q;
  logic [DATA_W-1:0] dacCode_d;
  logic daisy_q;
  logic daisy_d;
  logic rising_q;
  logic rising_d;
  logic chainOut_q;
  logic ctrlEn_q;
  logic [dcsi_pkg::CMD_W-1:0] lastCmd_q;
  logic ack_q;
  logic [31:0] readData_q;

  // Edge selection
  wire captureEdge = rising_q ? clkRise : clkFall;
  wire driveEdge = rising_q ? clkFall : clkRise;
  wire frameLow = ~frameSync;
  wire shifting = (frameState_q == dcsi_pkg::FR_SHIFT);
  wire takeBit = shifting & frameLow & ~frameRise & captureEdge;
  wire [dcsi_pkg::FRAME_BITS-1:0] nextWord = {shiftReg_q[dcsi_pkg::FRAME_BITS-2:0], dinSync};

  // Execute points
  wire standaloneExec = takeBit & ~daisy_q & (bitCount_q == dcsi_pkg::CNT_LAST);
  wire daisyExec = shifting & frameRise & daisy_q & (bitCount_q == dcsi_pkg::CNT_FULL);
  wire execNow = standaloneExec | daisyExec;
  wire [dcsi_pkg::FRAME_BITS-1:0] execWord = standaloneExec ? nextWord : shiftReg_q;
  wire [dcsi_pkg::CMD_W-1:0] execCmd = execWord[dcsi_pkg::FRAME_BITS-1 -: dcsi_pkg::CMD_W];
  // Narrow variants simply drop the trailing bits
  wire [DATA_W-1:0] execData = execWord[dcsi_pkg::FIELD_W-1 -: DATA_W];

  // Command decode
  wire cmdLoad = execNow & (execCmd == dcsi_pkg::CMD_LOAD);
  wire cmdReadback = execNow & (execCmd == dcsi_pkg::CMD_READBACK);
  wire cmdDaisyOff = execNow & (execCmd == dcsi_pkg::CMD_DAISY_OFF);
  wire cmdRising = execNow & (execCmd == dcsi_pkg::CMD_RISING);
  wire cmdZero = execNow & (execCmd == dcsi_pkg::CMD_CLR_ZERO);
  wire cmdMid = execNow & (execCmd == dcsi_pkg::CMD_CLR_MID);
  wire [DATA_W-1:0] midCode = DATA_W'(1) << (DATA_W - 1);
  wire [dcsi_pkg::FIELD_W-1:0] readbackField = dcsi_pkg::FIELD_W'(dacCode_q) << PAD;
  wire [dcsi_pkg::FRAME_BITS-1:0] readbackWord = {dcsi_pkg::CMD_NOP, readbackField};

  // Settings and DAC register: nop and reserved codes fall through every branch
  always_comb begin
    dacCode_d = dacCode_q;
    if (cmdLoad) begin
      dacCode_d = execData;
    end else if (cmdZero) begin
      dacCode_d = '0;
    end else if (cmdMid) begin
      dacCode_d = midCode;
    end
  end

  // No command sets these back; only reset restores them
  assign daisy_d = daisy_q & ~cmdDaisyOff;
  assign rising_d = rising_q | cmdRising;

  // Frame sequencing and bit counting
  always_comb begin
    frameState_d = frameState_q;
    shiftReg_d = shiftReg_q;
    bitCount_d = bitCount_q;
    case (frameState_q)
      dcsi_pkg::FR_IDLE: begin
        if (frameFall & ctrlEn_q) begin
          frameState_d = dcsi_pkg::FR_SHIFT;
          bitCount_d = '0;
        end
      end
      dcsi_pkg::FR_SHIFT: begin
        if (frameRise) begin
          // Short standalone frame ends here with no effect
          frameState_d = dcsi_pkg::FR_IDLE;
        end else if (takeBit) begin
          shiftReg_d = nextWord;
          if (bitCount_q != dcsi_pkg::CNT_FULL) begin
            bitCount_d = bitCount_q + 1'b1;
          end
          if (standaloneExec) begin
            frameState_d = dcsi_pkg::FR_DONE;
          end
        end
      end
      dcsi_pkg::FR_DONE: begin
        if (frameRise) begin
          frameState_d = dcsi_pkg::FR_IDLE;
        end
      end
      default: begin
        frameState_d = dcsi_pkg::FR_IDLE;
      end
    endcase
    if (cmdReadback) begin
      shiftReg_d = readbackWord;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      frameState_q <= dcsi_pkg::FR_IDLE;
      shiftReg_q <= dcsi_pkg::SHIFT_RESET;
      bitCount_q <= '0;
      dacCode_q <= '0;
      daisy_q <= dcsi_pkg::DAISY_RESET;
      rising_q <= dcsi_pkg::RISING_RESET;
    end else begin
      frameState_q <= frameState_d;
      shiftReg_q <= shiftReg_d;
      bitCount_q <= bitCount_d;
      dacCode_q <= dacCode_d;
      daisy_q <= daisy_d;
      rising_q <= rising_d;
    end
  end

  // Chain output follows the shifter top bit on the non-capture edge
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      chainOut_q <= 1'b0;
    end else if (shifting & frameLow & driveEdge) begin
      chainOut_q <= shiftReg_q[dcsi_pkg::FRAME_BITS-1];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lastCmd_q <= dcsi_pkg::CMD_NOP;
    end else if (execNow) begin
      lastCmd_q <= execCmd;
    end
  end

  assign chainOut = chainOut_q;
  assign dacCode = dacCode_q;

  // Avalon-MM slave: one wait cycle, then the access completes
  wire busReq = avs_read | avs_write;
  wire busWriteDone = avs_write & ack_q;
  wire selCtrl = (avs_address == dcsi_pkg::REG_CTRL);
  wire [31:0] statusWord = {{(32 - dcsi_pkg::ST_CNT_LSB - dcsi_pkg::CNT_W){1'b0}}, bitCount_q, 4'h0,
    (frameState_q == dcsi_pkg::FR_DONE), shifting, rising_q, daisy_q};
  wire [31:0] readMux = (avs_address == dcsi_pkg::REG_DAC) ? 32'(dacCode_q) :
    (avs_address == dcsi_pkg::REG_STATUS) ? statusWord :
    selCtrl ? 32'(ctrlEn_q) :
    (avs_address == dcsi_pkg::REG_LASTCMD) ? 32'(lastCmd_q) : 32'h0000_0000;

  assign avs_waitrequest = busReq & ~ack_q;
  assign avs_readdata = readData_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      readData_q <= 32'h0000_0000;
    end else begin
      ack_q <= busReq & ~ack_q;
      if (avs_read & ~ack_q) begin
        readData_q <= readMux;
      end
    end
  end

  // Clearing the enable stops new frames; a frame in progress completes
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrlEn_q <= dcsi_pkg::CTRL_EN_RESET;
    end else if (busWriteDone & selCtrl & avs_byteenable[0]) begin
      ctrlEn_q <= avs_writedata[dcsi_pkg::CTRL_EN_BIT];
    end
  end

  // Checks
  sequence s_exec_cmd(logic [3:0] c);
    execNow && execCmd == c;
  endsequence

  property p_load;
    @(posedge ref_clk) disable iff (!rst_n)
      s_exec_cmd(dcsi_pkg::CMD_LOAD) |=> (dacCode_q == $past(execData));
  endproperty
  a_load: assert property (p_load) else $error("Load command did not update DAC code");

  property p_zero;
    @(posedge ref_clk) disable iff (!rst_n)
      s_exec_cmd(dcsi_pkg::CMD_CLR_ZERO) |=> (dacCode_q == '0);
  endproperty
  a_zero: assert property (p_zero) else $error("Clear to zero failed");

  property p_mid;
    @(posedge ref_clk) disable iff (!rst_n)
      s_exec_cmd(dcsi_pkg::CMD_CLR_MID) |=> (dacCode_q == midCode) && $onehot(dacCode_q);
  endproperty
  a_mid: assert property (p_mid) else $error("Clear to midscale failed");

  property p_nop;
    @(posedge ref_clk) disable iff (!rst_n)
      s_exec_cmd(dcsi_pkg::CMD_NOP) |=> $stable(dacCode_q) && $stable(daisy_q) && $stable(rising_q);
  endproperty
  a_nop: assert property (p_nop) else $error("No-operation changed state");

  property p_gate;
    @(posedge ref_clk) disable iff (!rst_n)
      (frameSync && !cmdReadback) |=> $stable(shiftReg_q);
  endproperty
  a_gate: assert property (p_gate) else $error("Shifter moved while frame select high");

  property p_persist;
    @(posedge ref_clk) disable iff (!rst_n)
      (rising_q || !daisy_q) |=> (rising_q || !$past(rising_q)) && (!daisy_q || $past(daisy_q));
  endproperty
  a_persist: assert property (p_persist) else $error("Sticky setting reverted");

  sequence s_sa_last;
    takeBit && !daisy_q && bitCount_q == dcsi_pkg::CNT_LAST;
  endsequence

  property p_sa16;
    @(posedge ref_clk) disable iff (!rst_n)
      s_sa_last |-> execNow ##1 (frameState_q == dcsi_pkg::FR_DONE);
  endproperty
  a_sa16: assert property (p_sa16) else $error("Standalone sixteenth bit did not execute");

  property p_abort;
    @(posedge ref_clk) disable iff (!rst_n)
      (shifting && frameRise && !daisy_q) |-> !execNow ##1 $stable(dacCode_q) && frameState_q == dcsi_pkg::FR_IDLE;
  endproperty
  a_abort: assert property (p_abort) else $error("Short standalone frame not aborted");

  property p_done_hold;
    @(posedge ref_clk) disable iff (!rst_n)
      (frameState_q == dcsi_pkg::FR_DONE && !frameRise) |=> $stable(shiftReg_q) && !execNow;
  endproperty
  a_done_hold: assert property (p_done_hold) else $error("Clocks accepted after standalone transfer");

  property p_count_clear;
    @(posedge ref_clk) disable iff (!rst_n)
      (frameState_q == dcsi_pkg::FR_IDLE && frameFall && ctrlEn_q) |=> shifting && bitCount_q == '0;
  endproperty
  a_count_clear: assert property (p_count_clear) else $error("Counter not cleared at frame start");

endmodule // dcsi_serial_dac_if

// file: tb/dcsi_host_model.sv
// Host serial port model: drives frame select, shift clock and data, collects the chain output.
// Assumes ref_clk at 10 MHz; one shift clock period is 8 ref_clk cycles (800 ns).
`timescale 1ns/100ps
module dcsi_host_model (
  input wire logic ref_clk,
  input wire logic chainOut,
  output logic frameSelN,
  output logic shiftClk,
  output logic serialIn
);
  logic [31:0] rxWord;

  initial begin
    frameSelN = 1'b1;
    shiftClk = 1'b0;
    serialIn = 1'b0;
    rxWord = 32'h0;
  end

  // Data moves on the drive edge, so it is steady 4 cycles either side of capture
  task automatic send_frame(input logic [31:0] word, input int nBits, input logic riseCap, input logic selLow,
                            input logic doRaise);
    frameSelN <= ~selLow;
    repeat (4) @(posedge ref_clk);
    for (int i = nBits - 1; i >= 0; i--) begin
      serialIn <= word[i];
      shiftClk <= ~riseCap;
      repeat (4) @(posedge ref_clk);
      shiftClk <= riseCap;
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      rxWord = {rxWord[30:0], chainOut};
      @(posedge ref_clk);
    end
    // Clock stands low between frames; released data line shows no stale value
    shiftClk <= 1'b0;
    serialIn <= ~serialIn;
    repeat (4) @(posedge ref_clk);
    if (doRaise) begin
      end_frame();
    end
  endtask

  task automatic end_frame();
    frameSelN <= 1'b1;
    repeat (8) @(posedge ref_clk);
  endtask
endmodule // dcsi_host_model

// file: tb/tb.sv
// Self-checking bench: frames through the host model, registers over Avalon-MM.
// Assumes the design answers every bus access; a cycle ceiling cuts a hang short.
`timescale 1ns/100ps
module tb;
  typedef struct packed {
    logic [15:0] frame;
    logic [11:0] code;
  } dcsi_row_t;

  logic ref_clk, rst_n, chainOut, avs_read, avs_write, avs_waitrequest, riseCap;
  logic frameSelN, shiftClk, serialIn;
  logic [11:0] dacCode;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;
  dcsi_row_t rows [15] = '{'{16'h1abc, 12'habc}, '{16'hb123, 12'h000}, '{16'h1555, 12'h555},
    '{16'hc777, 12'h800}, '{16'h0fff, 12'h800}, '{16'h3111, 12'h800}, '{16'h4111, 12'h800},
    '{16'h5111, 12'h800}, '{16'h6111, 12'h800}, '{16'h7111, 12'h800}, '{16'h8111, 12'h800},
    '{16'hd111, 12'h800}, '{16'he111, 12'h800}, '{16'hf111, 12'h800}, '{16'h2000, 12'h800}};
  logic [3:0] regAddr [5] = '{4'h0, 4'h4, 4'h8, 4'hc, 4'h2};
  logic [31:0] regExp [5] = '{32'h0, 32'h1, 32'h1, 32'h0, 32'h0};

  dcsi_serial_dac_if #(.DATA_W(12)) dut_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .frameSelN(frameSelN), .shiftClk(shiftClk),
    .serialIn(serialIn), .chainOut(chainOut), .dacCode(dacCode), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest)
  );

  dcsi_host_model host_u (
    .ref_clk(ref_clk), .chainOut(chainOut), .frameSelN(frameSelN), .shiftClk(shiftClk),
    .serialIn(serialIn)
  );

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Ceiling well above the roughly 4200 cycles the sequence needs
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  task automatic check_code(input string what, input logic [11:0] exp, input logic [11:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Request stands until waitrequest is seen low at a rising edge; data is taken at that edge
  task automatic bus(input logic wr, input logic [3:0] addr, input logic [31:0] wdata, output logic [31:0] data);
    @(posedge ref_clk);
    avs_address <= addr;
    avs_writedata <= wdata;
    avs_write <= wr;
    avs_read <= ~wr;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    data = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic frame(input logic [31:0] w, input int n, input logic raise = 1'b1);
    host_u.send_frame(w, n, riseCap, 1'b1, raise);
  endtask

  initial begin
    rst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    riseCap = 1'b0;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    check_code("dac after reset", 12'h000, dacCode);
    foreach (regAddr[i]) begin
      bus(1'b0, regAddr[i], 32'h0, rd);
      check_word("reset register", regExp[i], rd);
    end
    foreach (rows[i]) begin
      frame({16'h0, rows[i].frame}, 16);
      check_code("row code", rows[i].code, dacCode);
    end
    frame(32'h0, 16);
    check_word("readback", 32'h0800, {16'h0, host_u.rxWord[15:0]});
    frame({16'h3c3c, 16'h1234}, 32);
    check_code("two device frame", 12'h234, dacCode);
    check_word("passed through", 32'h3c3c, {16'h0, host_u.rxWord[15:0]});
    frame(32'h1111, 16, 1'b0);
    repeat (20) @(posedge ref_clk);
    check_code("before late raise", 12'h234, dacCode);
    host_u.end_frame();
    check_code("after late raise", 12'h111, dacCode);
    host_u.send_frame(32'h1fff, 16, riseCap, 1'b0, 1'b1);
    check_code("unselected clocks", 12'h111, dacCode);
    frame(32'ha000, 16);
    bus(1'b0, 4'h4, 32'h0, rd);
    check_word("rising status", 32'h3, rd & 32'h3);
    riseCap = 1'b1;
    frame(32'h1321, 16);
    check_code("rising capture", 12'h321, dacCode);
    frame(32'h9000, 16);
    bus(1'b0, 4'h4, 32'h0, rd);
    check_word("standalone status", 32'h2, rd & 32'h3);
    frame(32'h1456, 16, 1'b0);
    check_code("sixteenth edge", 12'h456, dacCode);
    host_u.end_frame();
    frame({12'h0, 16'h1555, 4'ha}, 20);
    check_code("extra clocks", 12'h555, dacCode);
    frame(32'h1a, 8);
    check_code("aborted frame", 12'h555, dacCode);
    frame(32'h1777, 16);
    check_code("after abort", 12'h777, dacCode);
    bus(1'b1, 4'h8, 32'h0, rd);
    frame(32'h1aaa, 16);
    check_code("disabled frame", 12'h777, dacCode);
    bus(1'b1, 4'h0, 32'hfff, rd);
    bus(1'b0, 4'h8, 32'h0, rd);
    check_word("ctrl cleared", 32'h0, rd);
    bus(1'b1, 4'h8, 32'h1, rd);
    bus(1'b0, 4'h0, 32'h0, rd);
    check_word("dac read only", 32'h777, rd);
    bus(1'b0, 4'hc, 32'h0, rd);
    check_word("last command", 32'h1, rd);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (5) @(posedge ref_clk);
    check_code("dac second reset", 12'h000, dacCode);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    bus(1'b0, 4'h4, 32'h0, rd);
    check_word("status second reset", 32'h1, rd & 32'h3);
    riseCap = 1'b0;
    frame(32'h1abc, 16);
    check_code("falling capture again", 12'habc, dacCode);
    tally_and_finish();
  end
endmodule // tb
